// >>> design/chgsup_defines.vh
`ifndef CHGSUP_DEFINES_VH
`define CHGSUP_DEFINES_VH
// register offsets (byte addresses, one word each)
`define CHGSUP_REG_CTRL 8'h00
`define CHGSUP_REG_DCHG1 8'h04
`define CHGSUP_REG_DCHG2 8'h08
`define CHGSUP_REG_WDOG 8'h0C
`define CHGSUP_REG_STATUS 8'h10
`define CHGSUP_REG_CHGSET 8'h14
// control fields
`define CHGSUP_CTRL_LPSEL 0
`define CHGSUP_CTRL_THR_LP 1
`define CHGSUP_CTRL_IBUF 2
`define CHGSUP_CTRL_TRIG1 3
`define CHGSUP_CTRL_TRIG2 4
`define CHGSUP_CTRL_RST 32'h0000_0001
// discharge fields
`define CHGSUP_TH1_HI 7
`define CHGSUP_TH1_LO 2
`define CHGSUP_TH2_HI 5
`define CHGSUP_TH2_LO 3
`define CHGSUP_DCHG1_RST 32'h0000_0000
`define CHGSUP_DCHG2_RST 32'h0000_0000
// watchdog field
`define CHGSUP_WD_HI 6
`define CHGSUP_WD_LO 5
`define CHGSUP_WDOG_RST 32'h0000_0020
// timing, in the unit named
`define CHGSUP_CLK_KHZ 20000
`define CHGSUP_T_POR_MS 5
`define CHGSUP_T_WD1_MS 5500
`define CHGSUP_T_WD2_MS 88000
`define CHGSUP_T_WD3_MS 175000
`define CHGSUP_T_WDDEG_MS 10
`define CHGSUP_T_TOUT_MS 25
`define CHGSUP_T_TOUTMAX_MS 35
`define CHGSUP_T_DEG_US 100
`endif

// >>> design/chgsup_top.v
// Overview of operation
// - start reset when either supply is released
// - registers to defaults 5 ms after valid
// - host access opens 5 ms later
// - bus power: regulator on, indicator, present flag
// - latch input voltage and current limits
// - cell count loads defaults, then converter
// - battery only: low power, regulator off
// - low power throttle only when enabled
// - battery only: watch bus, serial ready
// - clearing low power enters performance mode
// - battery current buffer follows enable bit
// - threshold one bits 7:2, two percentage 5:3
// - separate deglitch per discharge level
// - level one trips throttle after deglitch
// - counters clear below threshold, level two
// - tripped level sets its status bit
// - watchdog period select bits 6:5
// - watchdog reset deglitched at least 10 ms
// - clock low past timeout resets serial
// - device never stretches the clock
// - indicator only when bus good, no fault
// - source lost swaps to source mode at once
//
// Added by the designer: the register addresses and strobed register access.
`include "chgsup_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module chgsup_top #(
   parameter CLK_KHZ = `CHGSUP_CLK_KHZ,
   parameter POR_CYC = `CHGSUP_T_POR_MS * `CHGSUP_CLK_KHZ,
   parameter WD1_CYC = `CHGSUP_T_WD1_MS * `CHGSUP_CLK_KHZ,
   parameter WD2_CYC = `CHGSUP_T_WD2_MS * `CHGSUP_CLK_KHZ,
   parameter WD3_CYC = `CHGSUP_T_WD3_MS * `CHGSUP_CLK_KHZ,
   parameter WDDEG_CYC = `CHGSUP_T_WDDEG_MS * `CHGSUP_CLK_KHZ,
   parameter TOUT_CYC = `CHGSUP_T_TOUT_MS * `CHGSUP_CLK_KHZ,
   parameter DEG_UNIT_CYC = `CHGSUP_T_DEG_US * `CHGSUP_CLK_KHZ / 1000
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // register port
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr_stb,
   input wire rd_stb,
   output reg [31:0] rdata,
   // supply comparators (asynchronous)
   input wire input_release,
   input wire battery_release,
   input wire converter_enable_ok,
   input wire below_ovp_fall,
   input wire fault_any,
   input wire force_conv_off,
   input wire source_lost,
   input wire serial_clock_in,
   input wire wd_reset_in,
   // analog measurements, already digitised
   input wire [7:0] input_voltage_meas,
   input wire [7:0] current_limit_pin,
   input wire [2:0] cell_count_pin,
   input wire [5:0] discharge_current,
   input wire comparator_throttle,
   // outputs
   output reg gate_drive_regulator,
   output reg adapter_good_indicator_o,
   output reg adapter_good_indicator_oe,
   output reg processor_throttle_output,
   output reg battery_current_buffer_on,
   output reg converter_on,
   output reg source_mode,
   output reg present_monitor_on,
   output reg serial_ready,
   output reg serial_reset,
   output reg [7:0] input_voltage_limit,
   output reg [7:0] input_current_limit,
   output reg [2:0] cell_count
);
   localparam S_OFF = 5'b00001;
   localparam S_WAIT_RST = 5'b00010;
   localparam S_WAIT_ACC = 5'b00100;
   localparam S_QUAL = 5'b01000;
   localparam S_RUN = 5'b10000;

   // two-flop synchronisers for all asynchronous levels
   // levels only: a pulse shorter than one cycle may be missed
   localparam NS = 9;
   wire [NS-1:0] raw_in = {wd_reset_in, serial_clock_in, source_lost, force_conv_off,
      fault_any, below_ovp_fall, converter_enable_ok, battery_release, input_release};
   reg [NS-1:0] meta_q;
   reg [NS-1:0] sync_q;
   always @(posedge clk) begin
      if (!rst_n) begin
         meta_q <= {NS{1'b0}};
         sync_q <= {NS{1'b0}};
      end else begin
         meta_q <= raw_in;
         sync_q <= meta_q;
      end
   end
   wire bus_ok = sync_q[0];
   wire bat_ok = sync_q[1];
   wire conv_ok = sync_q[2];
   wire ovp_ok = sync_q[3];
   wire flt = sync_q[4];
   wire foff = sync_q[5];
   wire lost = sync_q[6];
   wire scl_s = sync_q[7];
   wire wdr_s = sync_q[8];

   // threshold two as eighths of threshold one, select 0..7 -> (sel+1)/8
   function [5:0] pct_of;
      input [5:0] th;
      input [2:0] sel;
      reg [8:0] p;
      begin
         p = th * ({1'b0, sel} + 4'h1);
         pct_of = p[8:3];
      end
   endfunction

   // cell count from the pin code; a removed battery loads one-cell defaults
   function [2:0] cell_code;
      input [2:0] pin;
      begin
         case (pin)
            3'h0: cell_code = 3'h1;
            3'h6: cell_code = 3'h5;
            3'h7: cell_code = 3'h5;
            default: cell_code = pin;
         endcase
      end
   endfunction

   reg [4:0] st_q;
   reg [31:0] tmr_q;
   reg [31:0] ctrl_q, dchg1_q, dchg2_q, wdog_q;
   reg from_bus_q;
   reg [7:0] chgset_q;
   reg lvl1_flag_q, lvl2_flag_q;
   reg dflt_ok_q, present_q;
   reg [31:0] wd_cnt_q, wddeg_q, scl_cnt_q;
   wire access_ok = (st_q == S_QUAL) || (st_q == S_RUN);
   // writes before access opens are dropped, reads return zero
   wire wr = wr_stb && access_ok;
   wire wd_expire;
   wire soft_rst = (st_q == S_WAIT_RST) && (tmr_q == POR_CYC - 1);
   wire [5:0] th1 = dchg1_q[`CHGSUP_TH1_HI:`CHGSUP_TH1_LO];
   wire [5:0] th2 = pct_of(th1, dchg2_q[`CHGSUP_TH2_HI:`CHGSUP_TH2_LO]);
   wire qual = access_ok && bus_ok && !dflt_ok_q;

   // power-up sequencer
   always @(posedge clk) begin
      if (!rst_n) begin
         st_q <= S_OFF;
         tmr_q <= 32'h0000_0000;
         from_bus_q <= 1'b0;
      end else begin
         case (st_q)
            S_OFF: begin
               tmr_q <= 32'h0000_0000;
               if (bus_ok || bat_ok) begin
                  st_q <= S_WAIT_RST;
                  from_bus_q <= bus_ok;
               end
            end
            // one timer spans both waits and is cleared between them
            S_WAIT_RST: begin
               tmr_q <= soft_rst ? 32'h0000_0000 : tmr_q + 32'h0000_0001;
               if (soft_rst)
                  st_q <= S_WAIT_ACC;
            end
            S_WAIT_ACC: begin
               tmr_q <= tmr_q + 32'h0000_0001;
               if (tmr_q == POR_CYC - 1)
                  st_q <= S_QUAL;
            end
            S_QUAL: begin
               st_q <= S_RUN;
            end
            S_RUN: begin
               if (!bus_ok && !bat_ok)
                  st_q <= S_OFF;
               else if (bus_ok)
                  from_bus_q <= 1'b1;
            end
            default: st_q <= S_OFF;
         endcase
      end
   end

   // register file
   always @(posedge clk) begin
      if (!rst_n || soft_rst || wd_expire) begin
         ctrl_q <= `CHGSUP_CTRL_RST;
         dchg1_q <= `CHGSUP_DCHG1_RST;
         dchg2_q <= `CHGSUP_DCHG2_RST;
         // period kept across expiry so the host setting survives it
         if (!rst_n || soft_rst)
            wdog_q <= `CHGSUP_WDOG_RST;
      end else if (wr) begin
         case (addr)
            `CHGSUP_REG_CTRL: ctrl_q <= {27'h0, wdata[4:0]};
            `CHGSUP_REG_DCHG1: dchg1_q <= {24'h0, wdata[7:2], 2'h0};
            `CHGSUP_REG_DCHG2: dchg2_q <= {16'h0, wdata[15:8], 2'h0, wdata[5:3], 3'h0};
            `CHGSUP_REG_WDOG: wdog_q <= {25'h0, wdata[6:5], 5'h0};
            default: ;
         endcase
      end
   end

   // status flags: trip sets, write of one clears, set wins
   wire trip1, trip2;
   wire clr_stat = wr && (addr == `CHGSUP_REG_STATUS);
   always @(posedge clk) begin
      if (!rst_n || soft_rst) begin
         lvl1_flag_q <= 1'b0;
         lvl2_flag_q <= 1'b0;
      end else begin
         lvl1_flag_q <= trip1 | (lvl1_flag_q & ~(clr_stat & wdata[0]));
         lvl2_flag_q <= trip2 | (lvl2_flag_q & ~(clr_stat & wdata[1]));
      end
   end

   // read-only status view of flags and live state
   wire [31:0] status_word = {27'h0, source_mode, processor_throttle_output, present_q,
      lvl2_flag_q, lvl1_flag_q};

   always @(posedge clk) begin
      if (!rst_n) begin
         rdata <= 32'h0000_0000;
      end else if (rd_stb) begin
         if (!access_ok)
            rdata <= 32'h0000_0000;
         else case (addr)
            `CHGSUP_REG_CTRL: rdata <= ctrl_q;
            `CHGSUP_REG_DCHG1: rdata <= dchg1_q;
            `CHGSUP_REG_DCHG2: rdata <= dchg2_q;
            `CHGSUP_REG_WDOG: rdata <= wdog_q;
            `CHGSUP_REG_STATUS: rdata <= status_word;
            `CHGSUP_REG_CHGSET: rdata <= {24'h0, chgset_q};
            default: rdata <= 32'h0000_0000;
         endcase
      end
   end

   // discharge deglitch, one counter per level
   wire [1:0] above = {discharge_current > th2, discharge_current > th1};
   wire [1:0] en = {ctrl_q[`CHGSUP_CTRL_TRIG2], ctrl_q[`CHGSUP_CTRL_TRIG1]};
   wire [7:0] deg_sel [0:1];
   assign deg_sel[0] = dchg1_q[15:8];
   assign deg_sel[1] = dchg2_q[15:8];
   wire [1:0] trip;
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_lvl
         // counter stops one past its limit so a long event cannot wrap
         reg [31:0] cnt_q;
         wire [31:0] lim = ({24'h0, deg_sel[g]} + 32'h1) * DEG_UNIT_CYC;
         always @(posedge clk) begin
            if (!rst_n || !above[g] || !en[g])
               cnt_q <= 32'h0000_0000;
            else if (cnt_q <= lim)
               cnt_q <= cnt_q + 32'h0000_0001;
         end
         assign trip[g] = cnt_q > lim;
      end
   endgenerate
   assign trip1 = trip[0];
   assign trip2 = trip[1];

   // host watchdog and its reset deglitch
   reg [31:0] wd_lim;
   always @* begin
      case (wdog_q[`CHGSUP_WD_HI:`CHGSUP_WD_LO])
         2'b01: wd_lim = WD1_CYC;
         2'b10: wd_lim = WD2_CYC;
         2'b11: wd_lim = WD3_CYC;
         default: wd_lim = 32'h0000_0000;
      endcase
   end
   wire wd_on = (wd_lim != 32'h0000_0000) && (st_q == S_RUN);
   // a held reset input keeps the count at zero
   wire wdr_ok = wddeg_q >= WDDEG_CYC;
   assign wd_expire = wd_on && (wd_cnt_q >= wd_lim - 1);
   always @(posedge clk) begin
      if (!rst_n) begin
         wd_cnt_q <= 32'h0000_0000;
         wddeg_q <= 32'h0000_0000;
      end else begin
         wddeg_q <= !wdr_s ? 32'h0000_0000 : (wdr_ok ? wddeg_q : wddeg_q + 32'h0000_0001);
         if (!wd_on || wr || wd_expire || wdr_ok)
            wd_cnt_q <= 32'h0000_0000;
         else
            wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
      end
   end

   // serial clock low timeout; device itself never holds the clock low
   always @(posedge clk) begin
      if (!rst_n) begin
         scl_cnt_q <= 32'h0000_0000;
         serial_reset <= 1'b0;
      end else begin
         scl_cnt_q <= scl_s ? 32'h0000_0000 :
            (scl_cnt_q > TOUT_CYC ? scl_cnt_q : scl_cnt_q + 32'h0000_0001);
         serial_reset <= !scl_s && (scl_cnt_q == TOUT_CYC);
      end
   end

   // bus qualification: limits and cell defaults land before the converter starts
   always @(posedge clk) begin
      if (!rst_n || !bus_ok || st_q == S_OFF)
         dflt_ok_q <= 1'b0;
      else if (qual)
         dflt_ok_q <= 1'b1;
   end

   // adapter present flag once the part runs from the bus
   always @(posedge clk) begin
      if (!rst_n || soft_rst)
         present_q <= 1'b0;
      else
         present_q <= from_bus_q && bus_ok;
   end

   // power path outputs
   wire lp = ctrl_q[`CHGSUP_CTRL_LPSEL];
   // in low power with no bus only the comparator path may throttle
   wire lp_only = lp && !bus_ok;
   wire thr_lp = ctrl_q[`CHGSUP_CTRL_THR_LP] && comparator_throttle;
   wire thr_dchg = trip1 || trip2;

   always @(posedge clk) begin
      if (!rst_n) begin
         gate_drive_regulator <= 1'b0;
         adapter_good_indicator_o <= 1'b0;
         adapter_good_indicator_oe <= 1'b0;
         processor_throttle_output <= 1'b0;
         battery_current_buffer_on <= 1'b0;
         converter_on <= 1'b0;
         source_mode <= 1'b0;
         present_monitor_on <= 1'b0;
         serial_ready <= 1'b0;
         input_voltage_limit <= 8'h00;
         input_current_limit <= 8'h00;
         cell_count <= 3'h0;
         chgset_q <= 8'h00;
      end else begin
         // performance mode keeps the regulator up even on battery
         gate_drive_regulator <= (st_q != S_OFF) && (bus_ok || !lp);
         adapter_good_indicator_o <= 1'b0;
         // open drain, released means high
         adapter_good_indicator_oe <= !(bus_ok && conv_ok && ovp_ok && !flt && !foff);
         processor_throttle_output <= lp_only ? thr_lp : thr_dchg;
         battery_current_buffer_on <= ctrl_q[`CHGSUP_CTRL_IBUF];
         // the bus comparator only matters while the bus is absent
         present_monitor_on <= (st_q != S_OFF) && !bus_ok;
         serial_ready <= access_ok;
         if (qual) begin
            input_voltage_limit <= input_voltage_meas;
            input_current_limit <= current_limit_pin;
            cell_count <= cell_code(cell_count_pin);
            chgset_q <= {5'h0, cell_code(cell_count_pin)};
         end
         converter_on <= (st_q == S_RUN) && from_bus_q && bus_ok && !foff && dflt_ok_q;
         // latched: a returning bus does not drop the source role by itself
         if (st_q != S_RUN)
            source_mode <= 1'b0;
         else if (lost && from_bus_q)
            source_mode <= 1'b1;
      end
   end
endmodule // chgsup_top
`default_nettype wire

// >>> sim/chgsup_host.sv
`timescale 1ns/1ns
`default_nettype none
module chgsup_host (
   // bus
   input wire logic clk,
   input wire logic [31:0] rdata,
   output logic [7:0] addr,
   output logic [31:0] wdata,
   output logic wr_stb,
   output logic rd_stb
);
   initial begin
      addr = 8'h00;
      wdata = 32'h0;
      wr_stb = 1'h0;
      rd_stb = 1'h0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_stb <= 1'h1;
      @(posedge clk);
      wr_stb <= 1'h0;
   endtask
   // read data is registered on the strobe and held until the next read strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'h1;
      @(posedge clk);
      rd_stb <= 1'h0;
      @(posedge clk);
      v = rdata;
   endtask
endmodule // chgsup_host
`default_nettype wire

// >>> sim/chgsup_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module chgsup_asserts #(parameter int POR_CYC = 20, parameter int TOUT_CYC = 50) (
   // clock and inputs
   input wire logic clk,
   input wire logic rst_n,
   input wire logic serial_clock_in,
   input wire logic converter_enable_ok,
   input wire logic below_ovp_fall,
   input wire logic fault_any,
   input wire logic force_conv_off,
   // outputs
   input wire logic [31:0] rdata,
   input wire logic adapter_good_indicator_o,
   input wire logic adapter_good_indicator_oe,
   input wire logic serial_reset,
   input wire logic serial_ready,
   input wire logic converter_on,
   input wire logic gate_drive_regulator,
   input wire logic source_mode,
   input wire logic [7:0] input_voltage_limit
);
   localparam int LATE = TOUT_CYC + 10;
   int low_q;
   int up_q;
   logic hit_q;
   always @(posedge clk) begin
      if (!rst_n || serial_clock_in)
         low_q <= 0;
      else
         low_q <= low_q + 1;
      if (!rst_n)
         up_q <= 0;
      else if (up_q < 1000)
         up_q <= up_q + 1;
      if (!rst_n || serial_clock_in)
         hit_q <= 1'h0;
      else if (serial_reset)
         hit_q <= 1'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_ind_drive: assert property (adapter_good_indicator_o == 1'h0)
      else $error("open drain output driven high");
   a_ind_cond: assert property ((!converter_enable_ok || !below_ovp_fall || fault_any
      || force_conv_off) [*4] |=> adapter_good_indicator_oe)
      else $error("indicator high without good bus");
   a_reset_quiet: assert property (!$past(rst_n) |-> !converter_on && !gate_drive_regulator
      && !serial_ready && !source_mode && rdata == 32'h0)
      else $error("output active right after reset");
   a_no_early: assert property (converter_on |-> up_q > 2 * POR_CYC)
      else $error("converter on before reset spans");
   a_limits_held: assert property (converter_on && $past(converter_on)
      |-> $stable(input_voltage_limit))
      else $error("voltage limit moved while running");
   a_conv_ldo: assert property (converter_on |-> gate_drive_regulator)
      else $error("converter on without regulator");
   a_sreset_cause: assert property (serial_reset |-> low_q >= TOUT_CYC)
      else $error("serial reset too early");
   a_sreset_pulse: assert property (serial_reset |=> !serial_reset)
      else $error("serial reset longer than one cycle");
   a_sreset_late: assert property (low_q == LATE |-> hit_q)
      else $error("serial reset missed its deadline");
endmodule // chgsup_asserts
`default_nettype wire

// >>> sim/chgsup_top_bench.sv
`include "chgsup_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module chgsup_top_bench;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic input_release = 1'h0, battery_release = 1'h1, converter_enable_ok = 1'h0;
   logic below_ovp_fall = 1'h1, fault_any = 1'h0, force_conv_off = 1'h0, source_lost = 1'h0;
   logic serial_clock_in = 1'h1, wd_reset_in = 1'h0, comparator_throttle = 1'h0;
   logic [7:0] input_voltage_meas = 8'h5A, current_limit_pin = 8'h3C;
   logic [2:0] cell_count_pin = 3'h3;
   logic [5:0] discharge_current = 6'h00;
   logic [7:0] addr, input_voltage_limit, input_current_limit;
   logic [31:0] wdata, rdata, d;
   logic wr_stb, rd_stb, seen;
   wire gate_drive_regulator, adapter_good_indicator_o, adapter_good_indicator_oe;
   wire processor_throttle_output, battery_current_buffer_on, converter_on, source_mode;
   wire present_monitor_on, serial_ready, serial_reset;
   wire [2:0] cell_count;
   int n_errors = 0;
   int n_tests = 0;
   always #25 clk = ~clk;
   chgsup_host u_host (.clk, .rdata, .addr, .wdata, .wr_stb, .rd_stb);
   chgsup_top #(.POR_CYC(20), .WD1_CYC(100), .WD2_CYC(200), .WD3_CYC(300), .WDDEG_CYC(10),
      .TOUT_CYC(50), .DEG_UNIT_CYC(2)) u_dut (.clk, .rst_n, .addr, .wdata, .wr_stb, .rd_stb,
      .rdata, .input_release, .battery_release, .converter_enable_ok, .below_ovp_fall,
      .fault_any, .force_conv_off, .source_lost, .serial_clock_in, .wd_reset_in,
      .input_voltage_meas, .current_limit_pin, .cell_count_pin, .discharge_current,
      .comparator_throttle, .gate_drive_regulator, .adapter_good_indicator_o,
      .adapter_good_indicator_oe, .processor_throttle_output, .battery_current_buffer_on,
      .converter_on, .source_mode, .present_monitor_on, .serial_ready, .serial_reset,
      .input_voltage_limit, .input_current_limit, .cell_count);
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // sync, register reset span and access span before any host access
   task automatic rst_seq;
      rst_n <= 1'h0;
      cyc(10);
      rst_n <= 1'h1;
      cyc(70);
   endtask
   task automatic t_battery;
      chk("regulator", gate_drive_regulator, 1'h0);
      chk("monitor", present_monitor_on, 1'h1);
      chk("ready", serial_ready, 1'h1);
      u_host.rd(`CHGSUP_REG_CTRL, d);
      chk("ctrl", d, `CHGSUP_CTRL_RST);
      u_host.rd(`CHGSUP_REG_WDOG, d);
      chk("wdog", d, `CHGSUP_WDOG_RST);
      u_host.rd(8'h40, d);
      chk("unmapped", d, 32'h0);
      comparator_throttle <= 1'h1;
      cyc(5);
      chk("lp thr off", processor_throttle_output, 1'h0);
      u_host.wr(`CHGSUP_REG_CTRL, 32'h3);
      cyc(5);
      chk("lp thr on", processor_throttle_output, 1'h1);
      comparator_throttle <= 1'h0;
      u_host.wr(`CHGSUP_REG_CTRL, 32'h4);
      cyc(5);
      chk("perf ldo", gate_drive_regulator, 1'h1);
      chk("ibuf", battery_current_buffer_on, 1'h1);
      cyc(120);
      u_host.rd(`CHGSUP_REG_CTRL, d);
      chk("wd expiry", d, `CHGSUP_CTRL_RST);
      u_host.wr(`CHGSUP_REG_CTRL, 32'h4);
      wd_reset_in <= 1'h1;
      cyc(120);
      u_host.rd(`CHGSUP_REG_CTRL, d);
      chk("wd hold", d, 32'h4);
      wd_reset_in <= 1'h0;
      $display("battery test done");
   endtask
   // th1 10, th2 half of it; level two deglitch code 3, i.e. 8 cycles; DCHG1 drops its code, so level one waits 2
   task automatic t_discharge;
      u_host.wr(`CHGSUP_REG_DCHG1, 32'h328);
      u_host.wr(`CHGSUP_REG_DCHG2, 32'h318);
      u_host.wr(`CHGSUP_REG_CTRL, 32'h18);
      repeat (4) begin
         discharge_current <= 6'h06;
         cyc(5);
         discharge_current <= 6'h00;
         cyc(1);
      end
      chk("glitch", processor_throttle_output, 1'h0);
      discharge_current <= 6'h06;
      cyc(6);
      chk("early", processor_throttle_output, 1'h0);
      cyc(8);
      chk("lvl2 thr", processor_throttle_output, 1'h1);
      u_host.rd(`CHGSUP_REG_STATUS, d);
      chk("flags", d[1:0], 2'h2);
      discharge_current <= 6'h14;
      cyc(14);
      u_host.rd(`CHGSUP_REG_STATUS, d);
      chk("flags both", d[1:0], 2'h3);
      $display("discharge test done");
   endtask
   task automatic t_bus;
      cell_count_pin <= 3'h5;
      input_release <= 1'h1;
      converter_enable_ok <= 1'h1;
      rst_seq();
      cyc(30);
      chk("conv", converter_on, 1'h1);
      chk("ldo", gate_drive_regulator, 1'h1);
      chk("ind", adapter_good_indicator_oe, 1'h0);
      chk("vlim", input_voltage_limit, 8'h5A);
      chk("ilim", input_current_limit, 8'h3C);
      chk("cells", cell_count, 3'h5);
      chk("no monitor", present_monitor_on, 1'h0);
      input_voltage_meas <= 8'hA5;
      u_host.rd(`CHGSUP_REG_STATUS, d);
      chk("present", d[2], 1'h1);
      force_conv_off <= 1'h1;
      cyc(5);
      chk("conv off", converter_on, 1'h0);
      chk("ind off", adapter_good_indicator_oe, 1'h1);
      chk("vlim held", input_voltage_limit, 8'h5A);
      force_conv_off <= 1'h0;
      cyc(5);
      chk("ind back", adapter_good_indicator_oe, 1'h0);
      source_lost <= 1'h1;
      cyc(6);
      chk("swap", source_mode, 1'h1);
      fault_any <= 1'h1;
      cyc(6);
      chk("ind fault", adapter_good_indicator_oe, 1'h1);
      serial_clock_in <= 1'h0;
      seen = 1'h0;
      repeat (75) begin
         @(posedge clk);
         seen = seen | serial_reset;
      end
      serial_clock_in <= 1'h1;
      chk("sreset", seen, 1'h1);
      $display("bus test done");
   endtask
   initial begin
      rst_seq();
      t_battery();
      t_discharge();
      t_bus();
      stop_test();
   end
   initial begin
      cyc(5000);
      n_errors++;
      stop_test();
   end
endmodule // chgsup_top_bench
bind chgsup_top chgsup_asserts #(.POR_CYC(POR_CYC), .TOUT_CYC(TOUT_CYC)) u_chk (.clk,
   .rst_n, .serial_clock_in, .converter_enable_ok, .below_ovp_fall, .fault_any,
   .force_conv_off, .rdata, .adapter_good_indicator_o, .adapter_good_indicator_oe,
   .serial_reset, .serial_ready, .converter_on, .gate_drive_regulator, .source_mode,
   .input_voltage_limit);
`default_nettype wire
